// file: hw/gpm_power_datapath.sv
// Power mode sequencer, sample timing, registers and frame queue of the rate sensor
module gpm_power_datapath #(
	parameter int unsigned RAW_CYC = gpm_pkg::RAW_CYC,
	parameter int unsigned WAKE_CYC = gpm_pkg::WAKE_CYC,
	parameter int unsigned FAST_WAKE_CYC = gpm_pkg::FAST_WAKE_CYC,
	parameter int unsigned TEMP_ACTIVE_CYC = gpm_pkg::TEMP_ACTIVE_CYC,
	parameter int unsigned TEMP_FAST_CYC = gpm_pkg::TEMP_FAST_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port of the serial interface
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sensing element
	input wire logic [47:0] sense_rate,
	input wire logic [15:0] sense_temp,
	input wire logic sleep_trigger,
	output logic sense_power_en,
	output logic drive_power_en,
	// Status
	output logic [1:0] power_mode
);
	// Two-flop synchronisers for all pin inputs
	logic [64:0] sync1_r, sync2_r;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {sleep_trigger, sense_temp, sense_rate};
			sync2_r <= sync1_r;
		end
	end
	logic [47:0] rate_s;
	logic [15:0] temp_s;
	logic trig_s;
	assign rate_s = sync2_r[47:0];
	assign temp_s = sync2_r[63:48];
	assign trig_s = sync2_r[64];

	function automatic gpm_pkg::gpm_state_t mode_state(input logic [1:0] m);
		case (m)
			gpm_pkg::MODE_NORMAL: mode_state = gpm_pkg::ST_NORMAL;
			gpm_pkg::MODE_FAST: mode_state = gpm_pkg::ST_FAST;
			default: mode_state = gpm_pkg::ST_SUSPEND;
		endcase
	endfunction

	function automatic logic [7:0] byte_of(input logic [47:0] w, input logic [2:0] idx);
		byte_of = w[8*idx +: 8];
	endfunction

	// Register and state declarations
	logic [7:0] rate_cfg_r, rate_cfg_nxt;
	logic [7:0] decim_r, decim_nxt;
	logic [7:0] auto_r, auto_nxt;
	logic [1:0] req_mode_r, req_mode_nxt;
	gpm_pkg::gpm_state_t state_r, state_nxt;
	logic [31:0] wake_cnt_r, wake_cnt_nxt;
	logic [31:0] raw_cnt_r, raw_cnt_nxt;
	logic [31:0] temp_cnt_r, temp_cnt_nxt;
	logic [23:0] time_r, time_nxt;
	logic [15:0] temp_r, temp_nxt;
	logic [47:0] data_r, data_nxt;
	logic [47:0] q_mem_r [gpm_pkg::QUEUE_DEPTH];
	logic [47:0] q_mem_nxt [gpm_pkg::QUEUE_DEPTH];
	logic [2:0] q_wp_r, q_wp_nxt, q_rp_r, q_rp_nxt;
	logic [3:0] q_cnt_r, q_cnt_nxt;
	logic [2:0] byte_r, byte_nxt;
	logic [7:0] frame_r, frame_nxt;
	logic [7:0] rdata_nxt;
	logic [1:0] target;
	logic raw_tick, running, keep, q_full, take, push, pop, q_rd;
	logic q_empty, q_hold_empty_r, q_hold_empty_nxt;
	logic [7:0] decim_mask;

	// Filter, skid buffer and queue chain
	gpm_stream_if filt_if ();
	gpm_stream_if buf_if ();

	gpm_rate_filter u_filter (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.sample_tick(raw_tick),
		.run(running),
		.odr_code(rate_cfg_r[gpm_pkg::ODR_LSB +: 3]),
		.raw(rate_s),
		.out(filt_if.src)
	);

	gpm_skid u_skid (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in(filt_if.dst),
		.out(buf_if.src)
	);

	// Raw sampling clock and sensor time
	assign raw_tick = (raw_cnt_r == 32'(RAW_CYC - 1));
	assign running = (state_r == gpm_pkg::ST_NORMAL);

	always_comb begin
		raw_cnt_nxt = raw_tick ? 32'h0000_0000 : 32'(raw_cnt_r + 32'h0000_0001);
		// Time steps on the raw tick, the edge on which the filter samples raw data
		time_nxt = raw_tick ? 24'(time_r + 24'(gpm_pkg::RAW_TIME_STEP)) : time_r;
	end

	// Power mode sequencer
	always_comb begin
		target = req_mode_r;
		if (auto_r[gpm_pkg::AUTO_EN_BIT] && trig_s && req_mode_r == gpm_pkg::MODE_NORMAL) begin
			target = auto_r[gpm_pkg::AUTO_FAST_BIT] ? gpm_pkg::MODE_FAST : gpm_pkg::MODE_SUSPEND;
		end
	end

	always_comb begin
		state_nxt = state_r;
		wake_cnt_nxt = 32'h0000_0000;
		// Any mode reaches any other; normal only through a warm-up wait
		case (state_r)
			gpm_pkg::ST_SUSPEND: begin
				if (target == gpm_pkg::MODE_NORMAL) begin
					state_nxt = gpm_pkg::ST_WAKE;
				end else begin
					state_nxt = mode_state(target);
				end
			end
			gpm_pkg::ST_WAKE: begin
				if (target != gpm_pkg::MODE_NORMAL) begin
					state_nxt = mode_state(target);
				end else if (wake_cnt_r == 32'(WAKE_CYC - 1)) begin
					state_nxt = gpm_pkg::ST_NORMAL;
				end else begin
					wake_cnt_nxt = 32'(wake_cnt_r + 32'h0000_0001);
				end
			end
			gpm_pkg::ST_FAST: begin
				if (target == gpm_pkg::MODE_NORMAL) begin
					state_nxt = gpm_pkg::ST_FAST_WAKE;
				end else begin
					state_nxt = mode_state(target);
				end
			end
			gpm_pkg::ST_FAST_WAKE: begin
				if (target != gpm_pkg::MODE_NORMAL) begin
					state_nxt = mode_state(target);
				end else if (wake_cnt_r == 32'(FAST_WAKE_CYC - 1)) begin
					state_nxt = gpm_pkg::ST_NORMAL;
				end else begin
					wake_cnt_nxt = 32'(wake_cnt_r + 32'h0000_0001);
				end
			end
			gpm_pkg::ST_NORMAL: begin
				state_nxt = mode_state(target);
			end
			default: begin
				state_nxt = gpm_pkg::ST_SUSPEND;
			end
		endcase
	end

	always_comb begin
		power_mode = gpm_pkg::MODE_SUSPEND;
		case (state_r)
			gpm_pkg::ST_NORMAL: power_mode = gpm_pkg::MODE_NORMAL;
			gpm_pkg::ST_FAST: power_mode = gpm_pkg::MODE_FAST;
			gpm_pkg::ST_FAST_WAKE: power_mode = gpm_pkg::MODE_FAST;
			default: power_mode = gpm_pkg::MODE_SUSPEND;
		endcase
	end

	// Sensing part is off in both sleep modes; drive stays up in fast mode
	assign sense_power_en = (state_r == gpm_pkg::ST_NORMAL) || (state_r == gpm_pkg::ST_WAKE)
		|| (state_r == gpm_pkg::ST_FAST_WAKE);
	assign drive_power_en = (state_r != gpm_pkg::ST_SUSPEND);

	// Temperature update rate follows the gyro mode
	always_comb begin
		temp_cnt_nxt = 32'(temp_cnt_r + 32'h0000_0001);
		temp_nxt = temp_r;
		if (state_r == gpm_pkg::ST_NORMAL) begin
			if (temp_cnt_r >= 32'(TEMP_ACTIVE_CYC - 1)) begin
				temp_cnt_nxt = 32'h0000_0000;
				temp_nxt = temp_s;
			end
		end else if (state_r == gpm_pkg::ST_FAST) begin
			if (temp_cnt_r >= 32'(TEMP_FAST_CYC - 1)) begin
				temp_cnt_nxt = 32'h0000_0000;
				// Only eight bits are meaningful at the slow rate
				temp_nxt = {temp_s[15:8], 8'h00};
			end
		end else begin
			temp_cnt_nxt = 32'h0000_0000;
		end
	end

	// Frame acceptance with decimation
	assign decim_mask = 8'((9'h001 << decim_r[gpm_pkg::DECIM_LSB +: 3]) - 9'h001);
	assign keep = ((frame_r & decim_mask) == 8'h00);
	assign q_full = (q_cnt_r == 4'(gpm_pkg::QUEUE_DEPTH));
	// A full queue stalls the buffer rather than dropping a kept frame
	assign buf_if.ready = !keep || !q_full;
	assign take = buf_if.valid && buf_if.ready;
	assign push = take && keep;
	assign q_rd = reg_rd && (reg_addr == gpm_pkg::OFF_QUEUE) && (state_r != gpm_pkg::ST_SUSPEND);
	// Emptiness judged at the first byte, so no frame mixes marker and data
	assign q_empty = (byte_r == 3'h0) ? (q_cnt_r == 4'h0) : q_hold_empty_r;
	assign pop = q_rd && !q_empty && (byte_r == gpm_pkg::LAST_BYTE);

	always_comb begin
		q_mem_nxt = q_mem_r;
		q_wp_nxt = q_wp_r;
		q_rp_nxt = q_rp_r;
		q_cnt_nxt = q_cnt_r;
		byte_nxt = byte_r;
		q_hold_empty_nxt = q_rd ? q_empty : q_hold_empty_r;
		frame_nxt = take ? 8'(frame_r + 8'h01) : frame_r;
		data_nxt = take ? buf_if.data : data_r;
		if (push) begin
			q_mem_nxt[q_wp_r] = buf_if.data;
			q_wp_nxt = 3'(q_wp_r + 3'h1);
		end
		if (q_rd) begin
			byte_nxt = (byte_r == gpm_pkg::LAST_BYTE) ? 3'h0 : 3'(byte_r + 3'h1);
		end
		if (pop) begin
			q_rp_nxt = 3'(q_rp_r + 3'h1);
		end
		if (push && !pop) begin
			q_cnt_nxt = 4'(q_cnt_r + 4'h1);
		end else if (pop && !push) begin
			q_cnt_nxt = 4'(q_cnt_r - 4'h1);
		end
	end

	// Register writes and read data
	always_comb begin
		rate_cfg_nxt = rate_cfg_r;
		decim_nxt = decim_r;
		auto_nxt = auto_r;
		req_mode_nxt = req_mode_r;
		if (reg_wr) begin
			case (reg_addr)
				gpm_pkg::OFF_RATE_CFG: rate_cfg_nxt = {5'h00, reg_wdata[2:0]};
				gpm_pkg::OFF_DECIM: decim_nxt = {5'h00, reg_wdata[2:0]};
				gpm_pkg::OFF_AUTO: auto_nxt = {6'h00, reg_wdata[1:0]};
				gpm_pkg::OFF_MODE_CMD: begin
					if (reg_wdata[1:0] != 2'h3) begin
						req_mode_nxt = reg_wdata[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_nxt = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				gpm_pkg::OFF_TIME0: rdata_nxt = time_r[7:0];
				gpm_pkg::OFF_TIME1: rdata_nxt = time_r[15:8];
				gpm_pkg::OFF_TIME2: rdata_nxt = time_r[23:16];
				gpm_pkg::OFF_QUEUE: begin
					if (state_r == gpm_pkg::ST_SUSPEND) begin
						rdata_nxt = 8'h00;
					end else if (q_empty) begin
						rdata_nxt = byte_r[0] ? gpm_pkg::EMPTY_WORD[15:8] : gpm_pkg::EMPTY_WORD[7:0];
					end else begin
						rdata_nxt = byte_of(q_mem_r[q_rp_r], byte_r);
					end
				end
				gpm_pkg::OFF_RATE_CFG: rdata_nxt = rate_cfg_r;
				gpm_pkg::OFF_DECIM: rdata_nxt = decim_r;
				gpm_pkg::OFF_AUTO: rdata_nxt = auto_r;
				gpm_pkg::OFF_MODE_CMD: rdata_nxt = {6'h00, req_mode_r};
				gpm_pkg::OFF_MODE_STAT: rdata_nxt = {5'h00, (state_r != mode_state(target)), power_mode};
				gpm_pkg::OFF_TEMP_L: rdata_nxt = temp_r[7:0];
				gpm_pkg::OFF_TEMP_H: rdata_nxt = temp_r[15:8];
				default: begin
					if (reg_addr >= gpm_pkg::OFF_DATA0 && reg_addr <= gpm_pkg::OFF_DATA5) begin
						rdata_nxt = byte_of(data_r, 3'(reg_addr - gpm_pkg::OFF_DATA0));
					end else begin
						rdata_nxt = 8'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rate_cfg_r <= gpm_pkg::RATE_CFG_RST;
			decim_r <= gpm_pkg::DECIM_RST;
			auto_r <= gpm_pkg::AUTO_RST;
			req_mode_r <= gpm_pkg::MODE_SUSPEND;
			state_r <= gpm_pkg::ST_SUSPEND;
			wake_cnt_r <= '0;
			raw_cnt_r <= '0;
			temp_cnt_r <= '0;
			time_r <= '0;
			temp_r <= '0;
			data_r <= '0;
			q_wp_r <= '0;
			q_rp_r <= '0;
			q_cnt_r <= '0;
			byte_r <= '0;
			q_hold_empty_r <= 1'b0;
			frame_r <= '0;
			reg_rdata <= '0;
			for (int i = 0; i < gpm_pkg::QUEUE_DEPTH; i++) begin
				q_mem_r[i] <= '0;
			end
		end else begin
			rate_cfg_r <= rate_cfg_nxt;
			decim_r <= decim_nxt;
			auto_r <= auto_nxt;
			req_mode_r <= req_mode_nxt;
			state_r <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
			raw_cnt_r <= raw_cnt_nxt;
			temp_cnt_r <= temp_cnt_nxt;
			time_r <= time_nxt;
			temp_r <= temp_nxt;
			data_r <= data_nxt;
			q_mem_r <= q_mem_nxt;
			q_wp_r <= q_wp_nxt;
			q_rp_r <= q_rp_nxt;
			q_cnt_r <= q_cnt_nxt;
			byte_r <= byte_nxt;
			q_hold_empty_r <= q_hold_empty_nxt;
			frame_r <= frame_nxt;
			reg_rdata <= rdata_nxt;
		end
	end
endmodule

// file: hw/gpm_pkg.sv
// Constants, offsets and types shared by the rate sensor power and data path
package gpm_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned RAW_RATE_HZ = 6400;
	localparam int unsigned RAW_CYC = CLK_HZ / RAW_RATE_HZ;
	localparam int unsigned WAKE_MS = 50;
	localparam int unsigned WAKE_CYC = (CLK_HZ / 1000) * WAKE_MS;
	localparam int unsigned FAST_WAKE_MS = 10;
	localparam int unsigned FAST_WAKE_CYC = (CLK_HZ / 1000) * FAST_WAKE_MS;
	localparam int unsigned TEMP_ACTIVE_HZ = 100;
	localparam int unsigned TEMP_ACTIVE_CYC = CLK_HZ / TEMP_ACTIVE_HZ;
	localparam int unsigned TEMP_FAST_MILLIHZ = 800;
	localparam int unsigned TEMP_FAST_CYC = (CLK_HZ / TEMP_FAST_MILLIHZ) * 1000;
	// Register offsets
	localparam logic [7:0] OFF_TIME0 = 8'h18;
	localparam logic [7:0] OFF_TIME1 = 8'h19;
	localparam logic [7:0] OFF_TIME2 = 8'h1a;
	localparam logic [7:0] OFF_QUEUE = 8'h24;
	localparam logic [7:0] OFF_RATE_CFG = 8'h42;
	localparam logic [7:0] OFF_DECIM = 8'h45;
	localparam logic [7:0] OFF_AUTO = 8'h6c;
	localparam logic [7:0] OFF_MODE_CMD = 8'h70;
	localparam logic [7:0] OFF_MODE_STAT = 8'h71;
	localparam logic [7:0] OFF_TEMP_L = 8'h72;
	localparam logic [7:0] OFF_TEMP_H = 8'h73;
	localparam logic [7:0] OFF_DATA0 = 8'h74;
	localparam logic [7:0] OFF_DATA5 = 8'h79;
	// Reset values
	localparam logic [7:0] RATE_CFG_RST = 8'h02;
	localparam logic [7:0] DECIM_RST = 8'h00;
	localparam logic [7:0] AUTO_RST = 8'h00;
	// Fields
	localparam int unsigned ODR_LSB = 0;
	localparam int unsigned DECIM_LSB = 0;
	localparam int unsigned AUTO_EN_BIT = 0;
	localparam int unsigned AUTO_FAST_BIT = 1;
	localparam int unsigned STAT_BUSY_BIT = 2;
	localparam logic [7:0] RAW_TIME_STEP = 8'h04;
	// Mode codes
	localparam logic [1:0] MODE_SUSPEND = 2'h0;
	localparam logic [1:0] MODE_NORMAL = 2'h1;
	localparam logic [1:0] MODE_FAST = 2'h2;
	// Data words
	localparam logic [15:0] EMPTY_WORD = 16'h8000;
	localparam logic [15:0] SUBST_WORD = 16'h8001;
	localparam int unsigned AXES = 3;
	localparam int unsigned FRAME_W = 48;
	localparam int unsigned QUEUE_DEPTH = 8;
	localparam logic [2:0] LAST_BYTE = 3'h5;

	typedef enum logic [2:0] {
		ST_SUSPEND = 3'b000,
		ST_WAKE = 3'b001,
		ST_NORMAL = 3'b010,
		ST_FAST = 3'b011,
		ST_FAST_WAKE = 3'b100
	} gpm_state_t;
endpackage

// file: hw/gpm_stream_if.sv
// Valid/ready stream of rate frames between the data path modules
interface gpm_stream_if;
	logic valid;
	logic ready;
	logic [47:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface

// file: hw/gpm_rate_filter.sv
// Box-car low-pass and output-rate decimation of raw rate frames
module gpm_rate_filter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Control
	input wire logic sample_tick,
	input wire logic run,
	input wire logic [2:0] odr_code,
	input wire logic [47:0] raw,
	// Filtered frames
	gpm_stream_if.src out
);
	logic [7:0] cnt_r, cnt_nxt;
	logic signed [23:0] acc_r [3];
	logic signed [23:0] acc_nxt [3];
	logic [47:0] data_r, data_nxt;
	logic valid_r, valid_nxt;
	logic [7:0] ratio_m1;
	logic [3:0] shift;
	logic last;

	// Rate code n gives 25 Hz shifted up by n, so 256 raw samples down to 2
	assign ratio_m1 = 8'((9'h100 >> odr_code) - 9'h001);
	assign shift = 4'(4'h8 - {1'b0, odr_code});
	assign last = (cnt_r == ratio_m1);

	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++) begin : g_axis
			logic signed [23:0] sum;
			logic [15:0] avg;
			assign sum = acc_r[ax] + 24'(signed'(raw[ax*16 +: 16]));
			assign avg = 16'(sum >>> shift);
			always_comb begin
				acc_nxt[ax] = acc_r[ax];
				data_nxt[ax*16 +: 16] = data_r[ax*16 +: 16];
				if (!run) begin
					acc_nxt[ax] = '0;
				end else if (sample_tick) begin
					acc_nxt[ax] = last ? 24'sh00_0000 : sum;
					if (last) begin
						data_nxt[ax*16 +: 16] = (avg == gpm_pkg::EMPTY_WORD) ? gpm_pkg::SUBST_WORD : avg;
					end
				end
			end
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					acc_r[ax] <= '0;
				end else begin
					acc_r[ax] <= acc_nxt[ax];
				end
			end
		end
	endgenerate

	always_comb begin
		cnt_nxt = cnt_r;
		valid_nxt = valid_r && !out.ready;
		if (!run) begin
			cnt_nxt = '0;
		end else if (sample_tick) begin
			cnt_nxt = last ? 8'h00 : 8'(cnt_r + 8'h01);
			// Skid buffer downstream keeps this single slot from overrunning in a queue stall of up to two frames
			if (last) begin
				valid_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			data_r <= '0;
			valid_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			data_r <= data_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign out.valid = valid_r;
	assign out.data = data_r;
endmodule

// file: hw/gpm_skid.sv
// Two-entry frame buffer so a queue stall of up to two further frames loses no filtered frame
module gpm_skid (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Streams
	gpm_stream_if.dst in,
	gpm_stream_if.src out
);
	logic [47:0] mem_r [2];
	logic [47:0] mem_nxt [2];
	logic wp_r, wp_nxt, rp_r, rp_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in.ready = (cnt_r != 2'h2);
	assign out.valid = (cnt_r != 2'h0);
	assign out.data = mem_r[rp_r];
	assign push = in.valid && in.ready;
	assign pop = out.valid && out.ready;

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wp_r] = in.data;
			wp_nxt = !wp_r;
		end
		if (pop) begin
			rp_nxt = !rp_r;
		end
		if (push && !pop) begin
			cnt_nxt = 2'(cnt_r + 2'h1);
		end else if (pop && !push) begin
			cnt_nxt = 2'(cnt_r - 2'h1);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// file: test/gpm_host_model.sv
// Host side model driving the register port of the rate sensor
module gpm_host_model #(
	parameter int unsigned GAP_CYC = 4
) (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Device state
	input wire logic [1:0] power_mode
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Single writes only, never a burst
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk_sys);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		// Released bus shows inverse, not stale data
		reg_wdata = ~data;
		// Fixed settle time of GAP_CYC cycles after a write while asleep
		if (power_mode !== gpm_pkg::MODE_NORMAL)
			repeat (GAP_CYC) @(negedge clk_sys);
	endtask
	// One strobe per byte, idle gap on queue reads while asleep
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		if (addr == gpm_pkg::OFF_QUEUE && power_mode !== gpm_pkg::MODE_NORMAL)
			@(negedge clk_sys);
		@(negedge clk_sys);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		data = reg_rdata;
		reg_rd = 1'b0;
	endtask
endmodule

// file: test/gpm_power_datapath_properties.sv
// Concurrent checks on the ports of the rate sensor power and data path
module gpm_power_datapath_properties #(
	parameter int unsigned WAKE_CYC = gpm_pkg::WAKE_CYC,
	parameter int unsigned FAST_WAKE_CYC = gpm_pkg::FAST_WAKE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Sensing element
	input wire logic [47:0] sense_rate,
	input wire logic [15:0] sense_temp,
	input wire logic sleep_trigger,
	input wire logic sense_power_en,
	input wire logic drive_power_en,
	// Status
	input wire logic [1:0] power_mode
);
	logic [31:0] wake_cnt_r;
	logic [31:0] wake_cnt_nxt;
	logic [31:0] fast_cnt_r;
	logic [31:0] fast_cnt_nxt;
	// Cycles spent warming up, from suspend and from fast start-up
	always_comb begin
		wake_cnt_nxt = 32'h0000_0000;
		fast_cnt_nxt = 32'h0000_0000;
		if (sense_power_en && power_mode == gpm_pkg::MODE_SUSPEND)
			wake_cnt_nxt = wake_cnt_r + 32'h0000_0001;
		if (sense_power_en && power_mode == gpm_pkg::MODE_FAST)
			fast_cnt_nxt = fast_cnt_r + 32'h0000_0001;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wake_cnt_r <= 32'h0000_0000;
			fast_cnt_r <= 32'h0000_0000;
		end else begin
			wake_cnt_r <= wake_cnt_nxt;
			fast_cnt_r <= fast_cnt_nxt;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence cmd_wr(logic [1:0] m);
		reg_wr && reg_addr == gpm_pkg::OFF_MODE_CMD && reg_wdata == {6'h00, m};
	endsequence
	sequence status_rd;
		reg_rd && reg_addr == gpm_pkg::OFF_MODE_STAT;
	endsequence
	reset_state_a: assert property ($rose(nrst) |-> power_mode == 2'h0 && !drive_power_en && reg_rdata == 8'h00)
		else $error("state after reset wrong");
	status_read_a: assert property (status_rd |=> reg_rdata[1:0] == $past(power_mode))
		else $error("status read wrong");
	read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	normal_power_a: assert property (power_mode == gpm_pkg::MODE_NORMAL |-> sense_power_en && drive_power_en)
		else $error("normal without power");
	drive_rail_a: assert property (drive_power_en == (sense_power_en || power_mode != gpm_pkg::MODE_SUSPEND))
		else $error("drive rail wrong");
	fast_halt_a: assert property ($past(power_mode) == gpm_pkg::MODE_NORMAL && power_mode == gpm_pkg::MODE_FAST |-> !sense_power_en)
		else $error("sampling not halted");
	cmd_fast_a: assert property (cmd_wr(gpm_pkg::MODE_FAST) |-> ##[1:3] power_mode == gpm_pkg::MODE_FAST)
		else $error("fast request ignored");
	cmd_suspend_a: assert property (cmd_wr(gpm_pkg::MODE_SUSPEND) |-> ##[1:3] !drive_power_en)
		else $error("suspend request ignored");
	wake_time_a: assert property ($past(power_mode) == 2'h0 && power_mode == 2'h1 |-> wake_cnt_r + 3 >= WAKE_CYC)
		else $error("wake too early");
	wake_limit_a: assert property (wake_cnt_r <= WAKE_CYC + 3)
		else $error("wake too late");
	fast_wake_a: assert property (fast_cnt_r <= FAST_WAKE_CYC + 3)
		else $error("fast wake too late");
endmodule
bind gpm_power_datapath gpm_power_datapath_properties #(.WAKE_CYC(WAKE_CYC), .FAST_WAKE_CYC(FAST_WAKE_CYC)) u_props (
	.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense_rate(sense_rate), .sense_temp(sense_temp),
	.sleep_trigger(sleep_trigger), .sense_power_en(sense_power_en), .drive_power_en(drive_power_en),
	.power_mode(power_mode));

// file: test/gpm_power_datapath_tb.sv
// Self-checking bench of the rate sensor power and data path
module gpm_power_datapath_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned RAW = 20;
	localparam int unsigned WAKE = 50;
	localparam int unsigned FWAKE = 10;
	localparam logic [47:0] EMPTY3 = {3{gpm_pkg::EMPTY_WORD}};
	logic clk_sys, nrst, reg_wr, reg_rd, sleep_trigger, sense_power_en, drive_power_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [47:0] sense_rate, exp_f;
	logic [15:0] sense_temp;
	logic [1:0] power_mode;
	int errors, tests_run;
	gpm_power_datapath #(.RAW_CYC(RAW), .WAKE_CYC(WAKE), .FAST_WAKE_CYC(FWAKE), .TEMP_ACTIVE_CYC(30),
		.TEMP_FAST_CYC(300)) u_gpm_power_datapath (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense_rate(sense_rate),
		.sense_temp(sense_temp), .sleep_trigger(sleep_trigger), .sense_power_en(sense_power_en),
		.drive_power_en(drive_power_en), .power_mode(power_mode));
	gpm_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_mode(power_mode));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] fix(input logic [15:0] w);
		return (w == gpm_pkg::EMPTY_WORD) ? gpm_pkg::SUBST_WORD : w;
	endfunction
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] b);
		u_host.read_reg(a, b);
	endtask
	task automatic wait_mode(input logic [1:0] m, input int bound);
		logic [7:0] s;
		for (int i = 0; i < bound && power_mode !== m; i++)
			@(negedge clk_sys);
		check("power_mode", power_mode, m);
		rd(gpm_pkg::OFF_MODE_STAT, s);
		check("mode_status", s, {6'h00, m});
		if (power_mode !== m)
			stop_test();
	endtask
	task automatic read_frame(input logic [7:0] base, input logic [7:0] step, output logic [47:0] f);
		for (int i = 0; i < 6; i++)
			rd(base + step * i[7:0], f[8*i +: 8]);
	endtask
	task automatic drain(output int n);
		logic [47:0] f;
		n = 0;
		f = 48'h0;
		for (int i = 0; i < 20 && f !== EMPTY3; i++) begin
			read_frame(gpm_pkg::OFF_QUEUE, 8'h00, f);
			if (f !== EMPTY3) begin
				n++;
				check("queue", f, exp_f);
			end
		end
		check("queue_end", f, EMPTY3);
	endtask
	// Sensor time over three raw periods, read strobes exactly that far apart
	task automatic time_step();
		logic [7:0] a, b;
		rd(gpm_pkg::OFF_TIME0, a);
		repeat (3 * RAW - 2) @(negedge clk_sys);
		rd(gpm_pkg::OFF_TIME0, b);
		check("sensor_time", b, 8'(a + 8'h0c));
	endtask
	initial begin
		logic [7:0] b, h;
		logic [47:0] f;
		logic [31:0] v;
		int cnt;
		errors = 0;
		tests_run = 0;
		nrst = 1'b0;
		sleep_trigger = 1'b0;
		sense_temp = 16'h0000;
		void'($urandom(28));
		v = $urandom;
		sense_rate = {v[31:0], 16'h8000};
		exp_f = {fix(sense_rate[47:32]), fix(sense_rate[31:16]), fix(sense_rate[15:0])};
		repeat (10) @(negedge clk_sys);
		nrst = 1'b1;
		@(negedge clk_sys);
		check("mode", power_mode, gpm_pkg::MODE_SUSPEND);
		rd(gpm_pkg::OFF_RATE_CFG, b);
		check("rate_cfg", b, gpm_pkg::RATE_CFG_RST);
		rd(gpm_pkg::OFF_DECIM, b);
		check("decim", b, gpm_pkg::DECIM_RST);
		rd(gpm_pkg::OFF_AUTO, b);
		check("auto", b, gpm_pkg::AUTO_RST);
		rd(8'h00, b);
		check("unmapped", b, 8'h00);
		rd(gpm_pkg::OFF_QUEUE, b);
		check("queue_suspend", b, 8'h00);
		time_step();
		// Every rate code, random upper bits that must read back zero
		for (int c = 0; c < 8; c++) begin
			v = $urandom;
			u_host.write_reg(gpm_pkg::OFF_RATE_CFG, {v[7:3], c[2:0]});
			rd(gpm_pkg::OFF_RATE_CFG, b);
			check("rate_code", b, {5'h00, c[2:0]});
			check("mode_kept", power_mode, gpm_pkg::MODE_SUSPEND);
		end
		u_host.write_reg(gpm_pkg::OFF_MODE_CMD, 8'h01);
		rd(gpm_pkg::OFF_MODE_STAT, b);
		check("mode_busy", b, {5'h00, 1'b1, gpm_pkg::MODE_SUSPEND});
		wait_mode(gpm_pkg::MODE_NORMAL, WAKE + 10);
		time_step();
		sense_temp = 16'($urandom);
		repeat (40) @(negedge clk_sys);
		rd(gpm_pkg::OFF_TEMP_L, b);
		rd(gpm_pkg::OFF_TEMP_H, h);
		check("temp_active", {h, b}, sense_temp);
		read_frame(gpm_pkg::OFF_DATA0, 8'h01, f);
		check("data_regs", f, exp_f);
		// Frames kept over a fixed window, then read back in fast start-up
		for (int n = 0; n < 3; n += 2) begin
			u_host.write_reg(gpm_pkg::OFF_DECIM, n[7:0]);
			drain(cnt);
			repeat (16 * RAW) @(negedge clk_sys);
			u_host.write_reg(gpm_pkg::OFF_MODE_CMD, 8'h02);
			wait_mode(gpm_pkg::MODE_FAST, 5);
			drain(cnt);
			check("frames", cnt + 1 >= (8 >> n) && cnt <= (8 >> n) + 1, 1'b1);
			read_frame(gpm_pkg::OFF_QUEUE, 8'h00, f);
			check("still_empty", f, EMPTY3);
			rd(gpm_pkg::OFF_RATE_CFG, b);
			check("cfg_kept", b, 8'h07);
			sense_temp = 16'($urandom);
			repeat (310) @(negedge clk_sys);
			rd(gpm_pkg::OFF_TEMP_L, b);
			rd(gpm_pkg::OFF_TEMP_H, h);
			check("temp_fast", {h, b}, {sense_temp[15:8], 8'h00});
			u_host.write_reg(gpm_pkg::OFF_MODE_CMD, 8'h01);
			wait_mode(gpm_pkg::MODE_NORMAL, FWAKE + 10);
		end
		// Trigger-driven sleep into fast start-up, then into suspend
		for (int k = 0; k < 2; k++) begin
			u_host.write_reg(gpm_pkg::OFF_AUTO, k ? 8'h01 : 8'h03);
			sleep_trigger = 1'b1;
			wait_mode(k ? gpm_pkg::MODE_SUSPEND : gpm_pkg::MODE_FAST, 10);
			sleep_trigger = 1'b0;
			wait_mode(gpm_pkg::MODE_NORMAL, WAKE + 10);
		end
		u_host.write_reg(gpm_pkg::OFF_MODE_CMD, 8'h00);
		wait_mode(gpm_pkg::MODE_SUSPEND, 5);
		u_host.write_reg(gpm_pkg::OFF_MODE_CMD, 8'h02);
		wait_mode(gpm_pkg::MODE_FAST, 5);
		time_step();
		stop_test();
	end
endmodule
